// ==== cma_core_mem.sv ====
`timescale 1ns/1ns
// What this block does
// - Program memory byte addressed, even word alignment.
// - PC steps by two, bit zero zero.
// - Absolute target loads PC bits 20:1.
// - Relative offsets count instruction words.
// - Second words carry 1111 plus 12 literal bits.
// - Lone second word executes as no-operation.
// - Twelve-bit data address, sixteen 256-byte banks.
// - Unimplemented data locations read as zero.
// - Access bank needs no bank pointer.
// - USB engine writes general RAM concurrently.
// - USB engine reads IN payload from RAM.
// - Bank 13 holds descriptors when USB enabled.
// - Bank 13 is plain RAM when disabled.
// - Banked address is pointer plus operand.
// - Bank pointer upper nibble reads zero.
// - Load-bank instruction writes bank pointer.
// - Unimplemented bank writes dropped, reads zero.
// - Full-address move ignores bank pointer.
// - Other instructions use pointer or access bank.
// - Banked write F9h in bank 15 hits PC.
// - Access operands split between bank 0 and 15.
module cma_core_mem
    import cma_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Program counter control from the decoder
    input wire logic IW_VALID,
    input wire logic [15:0] IW_WORD,
    input wire logic IW_FIRST_OF_TWO,
    input wire cma_pcop_e PC_OP,
    input wire logic [19:0] PC_WORD_TARGET,
    input wire logic [10:0] PC_REL_WORDS,
    input wire logic LOAD_BANK,
    input wire logic [7:0] LOAD_BANK_VALUE,
    output logic [20:0] PC,
    output logic IW_IS_NOP,
    output logic [11:0] IW_LITERAL,
    // Core data access
    input wire cma_dreq_s CORE_REQ,
    output logic [7:0] CORE_RDATA,
    output logic [11:0] CORE_ADDR,
    output logic [7:0] BANK_POINTER,
    // USB engine access
    input wire logic USB_ENABLE,
    input wire logic USB_WR,
    input wire logic [11:0] USB_WADDR,
    input wire logic [7:0] USB_WDATA,
    input wire logic USB_RD,
    input wire logic [11:0] USB_RADDR,
    output logic [7:0] USB_RDATA,
    output logic USB_DESC_ACTIVE
);

    // ****************************************
    // Address decoding
    // ****************************************
    // Banked, access and full modes differ only in where the upper nibble
    // comes from; one function keeps the read and write paths from
    // drifting apart.
    function automatic logic [11:0] resolve(input cma_amode_e m,
                                            input logic [11:0] a,
                                            input logic [3:0] bank);
        logic [11:0] r;
        r = a;
        case (m)
            CMA_AM_FULL: r = a;
            CMA_AM_ACCESS: begin
                if (a[7:0] < ACCESS_SPLIT) begin
                    r = {BANK_ACCESS_LOW, a[7:0]};
                end else begin
                    r = {BANK_ACCESS_HIGH, a[7:0]};
                end
            end
            default: r = {bank, a[7:0]};
        endcase
        return r;
    endfunction

    // Everything below the special register window is general RAM, shared
    // with the USB engine; the window itself is not stored in the array.
    function automatic logic is_ram(input logic [11:0] a);
        return a < GPR_TOP;
    endfunction

    // Only the low nibble of the bank pointer exists as flops, so the upper
    // nibble can never hold a stale value that a later read would expose.
    logic [3:0] bank_r;
    logic [20:0] pc_r;
    logic [20:0] pc_nxt;
    logic prev_first_r;
    logic [7:0] ram [0:RAM_DEPTH-1];
    logic [11:0] core_addr;
    logic core_wr_ram;
    logic core_wr_pcl;
    logic core_wr_bank;
    logic [7:0] core_rdata_r;
    logic [7:0] usb_rdata_r;

    // The strobes decode the resolved address, so a banked write that lands
    // on a register behaves exactly like a full-address one.
    assign core_addr = resolve(CORE_REQ.mode, CORE_REQ.addr, bank_r);
    assign core_wr_ram = CORE_REQ.valid && CORE_REQ.write
                         && is_ram(core_addr);
    assign core_wr_pcl = CORE_REQ.valid && CORE_REQ.write
                         && core_addr == ADDR_PCL;
    assign core_wr_bank = CORE_REQ.valid && CORE_REQ.write
                          && core_addr == ADDR_BANK_PTR;

    // ****************************************
    // Program counter
    // ****************************************
    always_comb begin
        pc_nxt = pc_r;
        // A data write to the counter low byte outranks the decoder, so a
        // computed jump takes effect even in a cycle with a valid word.
        if (core_wr_pcl) begin
            pc_nxt = {pc_r[20:8], CORE_REQ.wdata[7:1], 1'b0};
        end else if (IW_VALID) begin
            case (PC_OP)
                CMA_PC_STEP: pc_nxt = pc_r + PC_STEP;
                CMA_PC_ABS: pc_nxt = {PC_WORD_TARGET, 1'b0};
                // The offset counts words, so it is doubled and taken from
                // the address of the following word.
                CMA_PC_REL: pc_nxt = pc_r + PC_STEP
                    + {{9{PC_REL_WORDS[10]}}, PC_REL_WORDS, 1'b0};
                CMA_PC_HOLD: pc_nxt = pc_r;
                default: pc_nxt = pc_r;
            endcase
        end
    end

    // Bit zero is forced again at the flop so that no path, however it is
    // extended later, can leave the counter on an odd byte.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= {pc_nxt[20:1], 1'b0};
        end
    end

    // The flag tracks whether the word just executed opened a pair, so a
    // skipped first word leaves the orphan second word as a no-operation.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_first_r <= 1'b0;
        end else if (IW_VALID) begin
            prev_first_r <= IW_FIRST_OF_TWO;
        end
    end

    // The flag is combinational because the decoder needs it in the same
    // cycle in which the orphan word arrives.
    assign IW_IS_NOP = IW_VALID
        && IW_WORD[WORD_W-1:TAG_LSB] == SECOND_WORD_TAG
        && !prev_first_r;
    // The literal is offered for every word; only the pairing logic decides
    // whether anything downstream uses it.
    assign IW_LITERAL = IW_WORD[TAG_LSB-1:0];
    assign PC = pc_r;

    // ****************************************
    // Bank pointer
    // ****************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bank_r <= BANK_PTR_RESET;
        // The load instruction wins over a data write to the pointer; one
        // word cannot mean both, so the order only matters for odd stimulus.
        end else if (LOAD_BANK) begin
            bank_r <= LOAD_BANK_VALUE[3:0];
        end else if (core_wr_bank) begin
            bank_r <= CORE_REQ.wdata[3:0];
        end
    end

    assign BANK_POINTER = {4'h0, bank_r};

    // ****************************************
    // Shared RAM
    // ****************************************
    // Core and USB writes both land in one array; a same-address collision
    // lets the core win, since software owns arbitration of shared buffers.
    always_ff @(posedge CLK) begin
        if (core_wr_ram) begin
            ram[core_addr] <= CORE_REQ.wdata;
        end
        if (USB_WR && is_ram(USB_WADDR)
            && !(core_wr_ram && core_addr == USB_WADDR)) begin
            ram[USB_WADDR] <= USB_WDATA;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            core_rdata_r <= 8'h00;
        // Read data stands until the next read, so the decoder may take it
        // a cycle later without holding the request.
        end else if (CORE_REQ.valid && !CORE_REQ.write) begin
            if (is_ram(core_addr)) begin
                core_rdata_r <= ram[core_addr];
            end else if (core_addr == ADDR_PCL) begin
                core_rdata_r <= pc_r[7:0];
            end else if (core_addr == ADDR_BANK_PTR) begin
                core_rdata_r <= {4'h0, bank_r};
            end else begin
                core_rdata_r <= 8'h00;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            usb_rdata_r <= 8'h00;
        // Reads outside general RAM return zero rather than any register,
        // because the engine has no business in the special window.
        end else if (USB_RD) begin
            usb_rdata_r <= is_ram(USB_RADDR) ? ram[USB_RADDR] : 8'h00;
        end
    end

    assign CORE_RDATA = core_rdata_r;
    assign USB_RDATA = usb_rdata_r;
    assign CORE_ADDR = core_addr;
    // Bank 13 is always stored as plain RAM; the flag only tells the engine
    // side that it is touching its descriptor table, which holds only while
    // the module is enabled.
    assign USB_DESC_ACTIVE = USB_ENABLE
        && USB_WADDR[11:8] == BANK_DESCRIPTOR;

    // ****************************************
    // Checks
    // ****************************************
    // Where it is cheap, the checks restate the address map independently
    // of the decode function.
    AST_PC_EVEN: assert property (@(posedge CLK) disable iff (RST)
        pc_r[0] == 1'b0) else $error("PC bit zero set");

    AST_PC_STEP: assert property (@(posedge CLK) disable iff (RST)
        IW_VALID && PC_OP == CMA_PC_STEP && !core_wr_pcl
        |=> pc_r == $past(pc_r) + PC_STEP) else $error("PC step wrong");

    AST_PC_ABS: assert property (@(posedge CLK) disable iff (RST)
        IW_VALID && PC_OP == CMA_PC_ABS && !core_wr_pcl
        |=> pc_r[20:1] == $past(PC_WORD_TARGET)) else $error("abs wrong");

    AST_LONE_NOP: assert property (@(posedge CLK) disable iff (RST)
        IW_VALID && IW_WORD[15:12] == SECOND_WORD_TAG && !prev_first_r
        |-> IW_IS_NOP) else $error("lone second word not nop");

    AST_BANKED: assert property (@(posedge CLK) disable iff (RST)
        CORE_REQ.mode == CMA_AM_BANKED
        |-> core_addr == {bank_r, CORE_REQ.addr[7:0]})
        else $error("banked address wrong");

    AST_ACCESS: assert property (@(posedge CLK) disable iff (RST)
        CORE_REQ.mode == CMA_AM_ACCESS
        |-> core_addr[11:8] == (CORE_REQ.addr[7:0] < ACCESS_SPLIT
            ? BANK_ACCESS_LOW : BANK_ACCESS_HIGH)) else $error("access map");

    AST_FULL: assert property (@(posedge CLK) disable iff (RST)
        CORE_REQ.mode == CMA_AM_FULL |-> core_addr == CORE_REQ.addr)
        else $error("full address altered");

    AST_LOADBANK: assert property (@(posedge CLK) disable iff (RST)
        LOAD_BANK |=> BANK_POINTER == {4'h0, $past(LOAD_BANK_VALUE[3:0])})
        else $error("load bank failed");

    AST_UNIMPL_ZERO: assert property (@(posedge CLK) disable iff (RST)
        CORE_REQ.valid && !CORE_REQ.write && !is_ram(core_addr)
        && core_addr != ADDR_PCL && core_addr != ADDR_BANK_PTR
        |=> CORE_RDATA == 8'h00) else $error("unimplemented read nonzero");

    // ****************************************
    // Program counter checks
    // ****************************************
    AST_PC_REL: assert property (@(posedge CLK) disable iff (RST)
        IW_VALID && PC_OP == CMA_PC_REL && !core_wr_pcl
        |=> pc_r == $past(pc_r) + PC_STEP
            + {{9{$past(PC_REL_WORDS[10])}}, $past(PC_REL_WORDS), 1'b0})
        else $error("relative branch wrong");

    AST_PC_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !core_wr_pcl && (!IW_VALID || PC_OP == CMA_PC_HOLD)
        |=> pc_r == $past(pc_r)) else $error("PC moved while held");

    AST_PCL_WRITE: assert property (@(posedge CLK) disable iff (RST)
        core_wr_pcl |=> pc_r[7:0] == {$past(CORE_REQ.wdata[7:1]), 1'b0}
        && pc_r[20:8] == $past(pc_r[20:8])) else $error("PC low write");

    AST_PAIRED_WORD: assert property (@(posedge CLK) disable iff (RST)
        IW_VALID && IW_WORD[WORD_W-1:TAG_LSB] == SECOND_WORD_TAG
        && prev_first_r |-> !IW_IS_NOP) else $error("paired word dropped");

    // ****************************************
    // Bank pointer checks
    // ****************************************
    AST_BANK_WRITE: assert property (@(posedge CLK) disable iff (RST)
        core_wr_bank && !LOAD_BANK
        |=> BANK_POINTER == {4'h0, $past(CORE_REQ.wdata[3:0])})
        else $error("bank pointer write lost");

    AST_BANK_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !LOAD_BANK && !core_wr_bank
        |=> BANK_POINTER == $past(BANK_POINTER)) else $error("bank drift");

    // ****************************************
    // Shared RAM checks
    // ****************************************
    AST_CORE_RAM_WR: assert property (@(posedge CLK) disable iff (RST)
        core_wr_ram |=> ram[$past(core_addr)] == $past(CORE_REQ.wdata))
        else $error("core write lost");

    AST_CORE_RAM_RD: assert property (@(posedge CLK) disable iff (RST)
        CORE_REQ.valid && !CORE_REQ.write && is_ram(core_addr)
        |=> CORE_RDATA == $past(ram[core_addr])) else $error("core read");

    AST_USB_RAM_WR: assert property (@(posedge CLK) disable iff (RST)
        USB_WR && is_ram(USB_WADDR)
        && !(core_wr_ram && core_addr == USB_WADDR)
        |=> ram[$past(USB_WADDR)] == $past(USB_WDATA))
        else $error("engine write lost");

    AST_USB_RAM_RD: assert property (@(posedge CLK) disable iff (RST)
        USB_RD && is_ram(USB_RADDR)
        |=> USB_RDATA == $past(ram[USB_RADDR])) else $error("engine read");

    AST_USB_RD_ZERO: assert property (@(posedge CLK) disable iff (RST)
        USB_RD && !is_ram(USB_RADDR) |=> USB_RDATA == 8'h00)
        else $error("engine read outside RAM nonzero");

    // ****************************************
    // Descriptor flag checks
    // ****************************************
    AST_DESC_OFF: assert property (@(posedge CLK) disable iff (RST)
        !USB_ENABLE |-> !USB_DESC_ACTIVE) else $error("descriptor flag");

    AST_DESC_ON: assert property (@(posedge CLK) disable iff (RST)
        USB_ENABLE && USB_WADDR[11:8] == BANK_DESCRIPTOR
        |-> USB_DESC_ACTIVE) else $error("descriptor flag missing");

endmodule

// ==== cma_pkg.sv ====
package cma_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int WORD_W = 16;

    // ****************************************
    // Program counter constants
    // ****************************************
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
    localparam int TAG_LSB = 12;

    // ****************************************
    // Data memory map
    // ****************************************
    localparam logic [3:0] BANK_ACCESS_LOW = 4'h0;
    localparam logic [3:0] BANK_ACCESS_HIGH = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] BANK_DESCRIPTOR = 4'hD;
    localparam logic [11:0] ADDR_PCL = 12'hFF9;
    localparam logic [11:0] ADDR_BANK_PTR = 12'hFE0;
    localparam logic [11:0] GPR_TOP = 12'hEB0;
    localparam logic [3:0] BANK_PTR_RESET = 4'h0;
    localparam int RAM_DEPTH = 4096;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        CMA_PC_STEP = 2'b00,
        CMA_PC_ABS = 2'b01,
        CMA_PC_REL = 2'b10,
        CMA_PC_HOLD = 2'b11
    } cma_pcop_e;

    typedef enum logic [1:0] {
        CMA_AM_BANKED = 2'b00,
        CMA_AM_ACCESS = 2'b01,
        CMA_AM_FULL = 2'b10
    } cma_amode_e;

    typedef struct packed {
        logic valid;
        logic write;
        cma_amode_e mode;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cma_dreq_s;

endpackage

// ==== cma_usb_model.sv ====
`timescale 1ns/1ns
module cma_usb_model (
    // Clock
    input wire logic CLK,
    // Engine side of the shared RAM
    output logic USB_WR,
    output logic [11:0] USB_WADDR,
    output logic [7:0] USB_WDATA,
    output logic USB_RD,
    output logic [11:0] USB_RADDR,
    input wire logic [7:0] USB_RDATA
);
    initial begin
        USB_WR = 1'b0;
        USB_RD = 1'b0;
        USB_WADDR = 12'h000;
        USB_WDATA = 8'h00;
        USB_RADDR = 12'h000;
    end
    // Released lines are inverted so a stale value can never match.
    task automatic put(input logic [11:0] a, input logic [7:0] d);
        @(negedge CLK);
        USB_WR = 1'b1;
        USB_WADDR = a;
        USB_WDATA = d;
        @(negedge CLK);
        USB_WR = 1'b0;
        USB_WADDR = ~a;
        USB_WDATA = ~d;
    endtask
    task automatic get(input logic [11:0] a, output logic [7:0] d);
        @(negedge CLK);
        USB_RD = 1'b1;
        USB_RADDR = a;
        @(negedge CLK);
        d = USB_RDATA;
        USB_RD = 1'b0;
        USB_RADDR = ~a;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench
    import cma_pkg::*;
;
    logic clk, rst, iw_valid, iw_first, ld_bank, nop, nop_s, usb_en;
    logic u_wr, u_rd, desc, desc_seen;
    logic [15:0] iw_word;
    cma_pcop_e pc_op;
    logic [19:0] pc_tgt;
    logic [10:0] pc_rel;
    logic [7:0] ld_val, rdata, bptr, u_wd, u_rdata, d;
    logic [20:0] pc;
    logic [11:0] lit, caddr, u_wa, u_ra, a;
    cma_dreq_s req;
    int mismatches, checked;
    cma_core_mem i_dut (.CLK(clk), .RST(rst), .IW_VALID(iw_valid),
        .IW_WORD(iw_word), .IW_FIRST_OF_TWO(iw_first), .PC_OP(pc_op),
        .PC_WORD_TARGET(pc_tgt), .PC_REL_WORDS(pc_rel), .LOAD_BANK(ld_bank),
        .LOAD_BANK_VALUE(ld_val), .PC(pc), .IW_IS_NOP(nop), .IW_LITERAL(lit),
        .CORE_REQ(req), .CORE_RDATA(rdata), .CORE_ADDR(caddr),
        .BANK_POINTER(bptr), .USB_ENABLE(usb_en), .USB_WR(u_wr),
        .USB_WADDR(u_wa), .USB_WDATA(u_wd), .USB_RD(u_rd), .USB_RADDR(u_ra),
        .USB_RDATA(u_rdata), .USB_DESC_ACTIVE(desc));
    cma_usb_model i_usb (.CLK(clk), .USB_WR(u_wr), .USB_WADDR(u_wa),
        .USB_WDATA(u_wd), .USB_RD(u_rd), .USB_RADDR(u_ra),
        .USB_RDATA(u_rdata));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (u_wr) desc_seen <= desc;
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input cma_amode_e m, input logic [11:0] ad,
        input logic w, input logic [7:0] wd);
        @(negedge clk);
        req = '{valid: 1'b1, write: w, mode: m, addr: ad, wdata: wd};
        #1 a = caddr;
        @(negedge clk);
        d = rdata;
        req.valid = 1'b0;
    endtask
    // The word stays valid so back-to-back words pair up.
    task automatic pcop(input cma_pcop_e op, input logic [15:0] w,
        input logic f);
        @(negedge clk);
        iw_valid = 1'b1;
        pc_op = op;
        iw_word = w;
        iw_first = f;
        #1 nop_s = nop;
    endtask
    task automatic idle;
        @(negedge clk);
        iw_valid = 1'b0;
    endtask
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {rst, iw_valid, iw_first, ld_bank, usb_en} = 5'h10;
        {iw_word, pc_tgt, pc_rel, ld_val} = '0;
        pc_op = CMA_PC_STEP;
        req = '0;
        mismatches = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(pc, 21'h0);
        chk(bptr, 8'h00);
        pcop(CMA_PC_STEP, 16'h0000, 1'b0);
        idle();
        chk(pc, 21'h2);
        pc_tgt = 20'h00003;
        pcop(CMA_PC_ABS, 16'h0000, 1'b0);
        idle();
        chk(pc, 21'h6);
        pc_rel = 11'h005;
        pcop(CMA_PC_REL, 16'h0000, 1'b0);
        idle();
        chk(pc, 21'h12);
        pc_rel = 11'h7FE;
        pcop(CMA_PC_REL, 16'h0000, 1'b0);
        idle();
        chk(pc, 21'h10);
        pcop(CMA_PC_HOLD, 16'h0000, 1'b0);
        idle();
        chk(pc, 21'h10);
        chk(pc[0], 1'b0);
        pcop(CMA_PC_STEP, 16'hF456, 1'b0);
        chk(nop_s, 1'b1);
        chk(lit, 12'h456);
        pcop(CMA_PC_STEP, 16'hC123, 1'b1);
        pcop(CMA_PC_STEP, 16'hF456, 1'b0);
        chk(nop_s, 1'b0);
        idle();
        @(negedge clk);
        ld_bank = 1'b1;
        ld_val = 8'hF3;
        @(negedge clk);
        ld_bank = 1'b0;
        chk(bptr, 8'h03);
        acc(CMA_AM_BANKED, 12'h045, 1'b1, 8'hA5);
        chk(a, 12'h345);
        acc(CMA_AM_FULL, 12'h345, 1'b0, 8'h00);
        chk(d, 8'hA5);
        acc(CMA_AM_FULL, 12'h023, 1'b1, 8'h77);
        chk(a, 12'h023);
        acc(CMA_AM_ACCESS, 12'h023, 1'b0, 8'h00);
        chk(d, 8'h77);
        acc(CMA_AM_ACCESS, 12'h05F, 1'b1, 8'h3C);
        chk(a, 12'h05F);
        acc(CMA_AM_FULL, 12'h05F, 1'b0, 8'h00);
        chk(d, 8'h3C);
        acc(CMA_AM_ACCESS, 12'h060, 1'b0, 8'h00);
        chk(a, 12'hF60);
        acc(CMA_AM_FULL, 12'hEAF, 1'b1, 8'h22);
        acc(CMA_AM_FULL, 12'hEB0, 1'b1, 8'h11);
        acc(CMA_AM_FULL, 12'hEB0, 1'b0, 8'h00);
        chk(d, 8'h00);
        acc(CMA_AM_FULL, 12'hEAF, 1'b0, 8'h00);
        chk(d, 8'h22);
        acc(CMA_AM_FULL, 12'hFE0, 1'b1, 8'hFF);
        chk(bptr, 8'h0F);
        acc(CMA_AM_BANKED, 12'h0F9, 1'b1, 8'h57);
        chk(a, 12'hFF9);
        chk(pc[7:0], 8'h56);
        usb_en = 1'b1;
        i_usb.put(12'hD05, 8'h5A);
        chk(desc_seen, 1'b1);
        acc(CMA_AM_FULL, 12'hD05, 1'b0, 8'h00);
        chk(d, 8'h5A);
        usb_en = 1'b0;
        i_usb.put(12'hD06, 8'h6B);
        chk(desc_seen, 1'b0);
        acc(CMA_AM_FULL, 12'hD06, 1'b0, 8'h00);
        chk(d, 8'h6B);
        acc(CMA_AM_FULL, 12'h200, 1'b1, 8'hC3);
        i_usb.get(12'h200, d);
        chk(d, 8'hC3);
        i_usb.get(12'hF00, d);
        chk(d, 8'h00);
        final_report();
    end
endmodule
